// [design/usb_addr_irq_defines.vh]
// Offsets, field positions, reset values and timing counts of the USB address and irq block.
`ifndef USB_ADDR_IRQ_DEFINES_VH
`define USB_ADDR_IRQ_DEFINES_VH

// Register byte offsets on the APB.
`define OFS_PORT_CTRL 8'h04
`define OFS_DEVICE_ADDRESS_CTRL 8'h08
`define OFS_IRQ_ENABLE_SET 8'h10
`define OFS_IRQ_ENABLE_CLEAR 8'h14
`define OFS_IRQ_ENABLE_VIEW 8'h18
`define OFS_IRQ_PENDING_VIEW 8'h1C
`define OFS_IRQ_PENDING_CLEAR 8'h20

// Port control fields.
`define POS_REMOTE_WAKE_ALLOW 4

// Device address control fields.
`define ADDR_VALUE_W 7
`define POS_FUNCTION_ENDPOINTS_ON 8
`define RST_DEVICE_ADDRESS 7'h00
`define RST_FUNCTION_ENDPOINTS_ON 1'b1

// Interrupt vector layout.
`define IRQ_W 14
`define POS_SUSPEND_IRQ 8
`define POS_RESUME_IRQ 9
`define POS_EXTERNAL_RESUME_IRQ 10
`define POS_FRAME_START_IRQ 11
`define POS_FIXED_ONE_POSITION 12
`define POS_WAKEUP_IRQ 13
`define MASK_WRITABLE 14'h2FFF
`define MASK_FIXED_ONES 14'h1000
`define RST_IRQ_MASK 14'h0200
`define PENDING_CLEARABLE 14'h3F00

// Timing.
`define SYS_CLK_MHZ 50
`define SUSPEND_TIME_US 3000

`endif

// [design/usb_device_addr_and_irq_regs.v]
// Address, function enable, remote wake and interrupt registers of a USB device port.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "usb_addr_irq_defines.vh"

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - Hold remote wakeup enable bit, one enables.
// - Seven-bit address field, cleared by reset.
// - Function enable at bit 8, readable.
// - Data transfers only while function enabled.
// - Endpoint n interrupt at bit n.
// - Bus event interrupts at bits 8-11, 13.
// - Enable write sets mask bits written one.
// - Disable write clears mask bits written one.
// - Bus event interrupts enabled and disabled likewise.
// - Mask register shows enabled sources as one.
// - Mask bit 12 reads one, not controllable.
// - Resume interrupt enabled in mask at reset.
// - Status shares mask layout, bus reset bit 12.
// - End of bus reset sets its status.
// - Suspend status after 3ms bus idle.
module usb_device_addr_and_irq_regs #(
   parameter integer SUSPEND_CYCLES = `SUSPEND_TIME_US * `SYS_CLK_MHZ,
   parameter integer IDLE_W = 18
) (
   input wire sys_clk,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [7:0] endpointIrq,
   input wire busActivity,
   input wire resumeDetected,
   input wire externalResumeDone,
   input wire frameStartSeen,
   input wire busResetDone,
   output wire [6:0] deviceAddressValue,
   output wire functionEndpointsOn,
   output wire remoteWakeAllow,
   output wire suspendMode,
   output wire irq
);

   localparam integer IDLE_LAST_FULL = SUSPEND_CYCLES - 1;
   localparam [IDLE_W-1:0] IDLE_LAST = IDLE_LAST_FULL[IDLE_W-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   reg remoteWake_reg;
   reg [6:0] deviceAddress_reg;
   reg functionOn_reg;
   reg [`IRQ_W-1:0] irqMask_reg;
   reg [`IRQ_W-1:0] irqMask_next;
   reg [`IRQ_W-1:0] pending_reg;
   wire [`IRQ_W-1:0] pending_next;
   reg [IDLE_W-1:0] idleCount_reg;
   reg [IDLE_W-1:0] idleCount_next;
   reg suspended_reg;
   reg suspended_next;
   reg [31:0] readData;
   reg addrHit;

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode.

   wire setupPhase;
   wire accessPhase;
   wire writeStrobe;
   wire [`IRQ_W-1:0] wrBits;
   wire [`IRQ_W-1:0] pendingSet;
   wire [`IRQ_W-1:0] pendingClear;
   wire [`IRQ_W-1:0] maskView;
   wire suspendEntry;

   assign setupPhase = psel & ~penable;
   assign accessPhase = psel & penable;
   assign writeStrobe = accessPhase & pwrite & addrHit;
   assign wrBits = pwdata[`IRQ_W-1:0];

   // Every access completes in its first access cycle, so no wait states.
   assign pready = 1'b1;
   assign pslverr = accessPhase & ~addrHit;

   always @* begin
      addrHit = 1'b1;
      case (paddr)
         `OFS_PORT_CTRL: addrHit = 1'b1;
         `OFS_DEVICE_ADDRESS_CTRL: addrHit = 1'b1;
         `OFS_IRQ_ENABLE_SET: addrHit = 1'b1;
         `OFS_IRQ_ENABLE_CLEAR: addrHit = 1'b1;
         `OFS_IRQ_ENABLE_VIEW: addrHit = 1'b1;
         `OFS_IRQ_PENDING_VIEW: addrHit = 1'b1;
         `OFS_IRQ_PENDING_CLEAR: addrHit = 1'b1;
         default: addrHit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.

   // Bit 12 is not stored; it is forced to one on every read of the mask.
   assign maskView = irqMask_reg | `MASK_FIXED_ONES;

   always @* begin
      readData = 32'h0000_0000;
      case (paddr)
         `OFS_PORT_CTRL: begin
            readData[`POS_REMOTE_WAKE_ALLOW] = remoteWake_reg;
         end
         `OFS_DEVICE_ADDRESS_CTRL: begin
            readData[`ADDR_VALUE_W-1:0] = deviceAddress_reg;
            readData[`POS_FUNCTION_ENDPOINTS_ON] = functionOn_reg;
         end
         `OFS_IRQ_ENABLE_VIEW: begin
            readData[`IRQ_W-1:0] = maskView;
         end
         `OFS_IRQ_PENDING_VIEW: begin
            readData[`IRQ_W-1:0] = pending_reg;
         end
         default: begin
            readData = 32'h0000_0000;
         end
      endcase
   end

   // Read data is captured in the setup cycle so it is valid from a flip-flop
   // throughout the single access cycle.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (setupPhase & ~pwrite) begin
         prdata <= readData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Port control and device address.

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         remoteWake_reg <= 1'b0;
      end else if (writeStrobe && paddr == `OFS_PORT_CTRL) begin
         remoteWake_reg <= pwdata[`POS_REMOTE_WAKE_ALLOW];
      end
   end

   // A bus reset returns the device to the default address, like a system reset, except when a write to the address register comes in the same cycle.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         deviceAddress_reg <= `RST_DEVICE_ADDRESS;
         functionOn_reg <= `RST_FUNCTION_ENDPOINTS_ON;
      end else if (writeStrobe && paddr == `OFS_DEVICE_ADDRESS_CTRL) begin
         deviceAddress_reg <= pwdata[`ADDR_VALUE_W-1:0];
         functionOn_reg <= pwdata[`POS_FUNCTION_ENDPOINTS_ON];
      end else if (busResetDone) begin
         deviceAddress_reg <= `RST_DEVICE_ADDRESS;
      end
   end

   assign deviceAddressValue = deviceAddress_reg;
   assign remoteWakeAllow = remoteWake_reg;

   // The serial engine only answers data packets while this is high.
   assign functionEndpointsOn = functionOn_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt mask.

   always @* begin
      irqMask_next = irqMask_reg;
      if (writeStrobe && paddr == `OFS_IRQ_ENABLE_SET) begin
         irqMask_next = irqMask_reg | (wrBits & `MASK_WRITABLE);
      end else if (writeStrobe && paddr == `OFS_IRQ_ENABLE_CLEAR) begin
         irqMask_next = irqMask_reg & ~(wrBits & `MASK_WRITABLE);
      end
   end

   // Resume starts enabled so a host resume is seen after the port logic is
   // powered down in suspend.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irqMask_reg <= `RST_IRQ_MASK;
      end else begin
         irqMask_reg <= irqMask_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Suspend detection.

   always @* begin
      idleCount_next = idleCount_reg;
      suspended_next = suspended_reg;
      if (busActivity) begin
         idleCount_next = {IDLE_W{1'b0}};
         suspended_next = 1'b0;
      end else if (!suspended_reg) begin
         if (idleCount_reg == IDLE_LAST) begin
            idleCount_next = {IDLE_W{1'b0}};
            suspended_next = 1'b1;
         end else begin
            idleCount_next = idleCount_reg + 1'b1;
         end
      end
   end

   assign suspendEntry = ~suspended_reg & suspended_next;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         idleCount_reg <= {IDLE_W{1'b0}};
         suspended_reg <= 1'b0;
      end else begin
         idleCount_reg <= idleCount_next;
         suspended_reg <= suspended_next;
      end
   end

   assign suspendMode = suspended_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status.

   assign pendingSet[7:0] = endpointIrq;
   assign pendingSet[`POS_SUSPEND_IRQ] = suspendEntry;
   assign pendingSet[`POS_RESUME_IRQ] = resumeDetected;
   assign pendingSet[`POS_EXTERNAL_RESUME_IRQ] = externalResumeDone;
   assign pendingSet[`POS_FRAME_START_IRQ] = frameStartSeen;
   assign pendingSet[`POS_FIXED_ONE_POSITION] = busResetDone;
   assign pendingSet[`POS_WAKEUP_IRQ] = resumeDetected | busResetDone;

   assign pendingClear = (writeStrobe && paddr == `OFS_IRQ_PENDING_CLEAR) ?
                         (wrBits & `PENDING_CLEARABLE) : {`IRQ_W{1'b0}};

   // Endpoint bits mirror the endpoint level, which is cleared at the endpoint
   // itself; bus event bits are sticky and a new event beats a clear.
   genvar i;
   generate
      for (i = 0; i < `IRQ_W; i = i + 1) begin : gPending
         if (i < 8) begin : gLevel
            assign pending_next[i] = pendingSet[i];
         end else begin : gSticky
            assign pending_next[i] = pendingSet[i] | (pending_reg[i] & ~pendingClear[i]);
         end
      end
   endgenerate

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pending_reg <= {`IRQ_W{1'b0}};
      end else begin
         pending_reg <= pending_next;
      end
   end

   assign irq = |(pending_reg & maskView);

endmodule // usb_device_addr_and_irq_regs

// [tb/usb_addr_irq_sva.sv]
// Port assertions for the USB address and irq register block.
`timescale 1ns/1ns
`include "usb_addr_irq_defines.vh"
module usb_addr_irq_sva (
   input wire sys_clk,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [7:0] endpointIrq,
   input wire busActivity,
   input wire busResetDone,
   input wire [6:0] deviceAddressValue,
   input wire functionEndpointsOn,
   input wire remoteWakeAllow,
   input wire suspendMode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire acc = psel && penable && pwrite;
   wire wr8 = acc && paddr == `OFS_DEVICE_ADDRESS_CTRL;
   wire setup = psel && !penable && !pwrite;
   addr_write_a: assert property (wr8 && !busResetDone |=>
      deviceAddressValue == $past(pwdata[6:0])) else $error("address not stored");
   fen_write_a: assert property (wr8 |=>
      functionEndpointsOn == $past(pwdata[8])) else $error("function enable not stored");
   wake_write_a: assert property (acc && paddr == `OFS_PORT_CTRL |=>
      remoteWakeAllow == $past(pwdata[4])) else $error("remote wake not stored");
   bus_reset_a: assert property (busResetDone && !wr8 |=>
      deviceAddressValue == 7'h00) else $error("address kept over bus reset");
   fixed_one_a: assert property (setup && paddr == `OFS_IRQ_ENABLE_VIEW |=>
      prdata[12]) else $error("mask bit 12 reads zero");
   mask_upper_a: assert property (setup && paddr == `OFS_IRQ_ENABLE_VIEW |=>
      prdata[31:14] == 18'h0) else $error("mask upper bits set");
   wo_read_a: assert property (setup && paddr[7:3] == 5'h02 |=>
      prdata == 32'h0000_0000) else $error("write-only register reads nonzero");
   suspend_exit_a: assert property (busActivity |=> !suspendMode)
      else $error("suspend held with bus active");
endmodule // usb_addr_irq_sva
bind usb_device_addr_and_irq_regs usb_addr_irq_sva u_sva (.sys_clk(sys_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .endpointIrq(endpointIrq),
   .busActivity(busActivity), .busResetDone(busResetDone),
   .deviceAddressValue(deviceAddressValue), .functionEndpointsOn(functionEndpointsOn),
   .remoteWakeAllow(remoteWakeAllow), .suspendMode(suspendMode));

// [tb/usb_device_addr_and_irq_regs_bench.sv]
// Self-checking bench of the USB address and irq registers.
`timescale 1ns/1ns
`include "usb_addr_irq_defines.vh"
module usb_device_addr_and_irq_regs_bench;
   reg sys_clk, rstn, psel, penable, pwrite, evtGo, idle, err;
   reg [7:0] paddr, endpointIrq;
   reg [31:0] pwdata, rd, seed, v;
   reg [2:0] evtSel;
   reg [13:0] m;
   integer bad_count, total_checks, i;
   wire [31:0] prdata;
   wire [6:0] deviceAddressValue;
   wire pready, pslverr, busActivity, resumeDetected, externalResumeDone, frameStartSeen;
   wire busResetDone, functionEndpointsOn, remoteWakeAllow, suspendMode, irq;
   usb_device_addr_and_irq_regs #(.SUSPEND_CYCLES(20)) u_usb_device_addr_and_irq_regs (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .endpointIrq(endpointIrq), .busActivity(busActivity), .resumeDetected(resumeDetected),
      .externalResumeDone(externalResumeDone), .frameStartSeen(frameStartSeen),
      .busResetDone(busResetDone), .deviceAddressValue(deviceAddressValue),
      .functionEndpointsOn(functionEndpointsOn), .remoteWakeAllow(remoteWakeAllow),
      .suspendMode(suspendMode), .irq(irq));
   usb_host_model u_usb_host_model (.sys_clk(sys_clk), .rstn(rstn), .evtSel(evtSel),
      .evtGo(evtGo), .idle(idle), .busActivity(busActivity), .resumeDetected(resumeDetected),
      .externalResumeDone(externalResumeDone), .frameStartSeen(frameStartSeen),
      .busResetDone(busResetDone));
   initial begin
      sys_clk = 0;
      forever #10 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function [31:0] nxt(input [31:0] s);
      nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Bit 12 is dropped and forced back, as software can never move it.
   function [13:0] newMask(input [13:0] o, input [31:0] s, input [31:0] c);
      newMask = ((o | s[13:0]) & ~c[13:0] & 14'h2FFF) | 14'h1000;
   endfunction
   function [31:0] evtBits(input integer k);
      case (k)
         1: evtBits = 32'h0000_2200;
         2: evtBits = 32'h0000_0400;
         3: evtBits = 32'h0000_0800;
         default: evtBits = 32'h0000_3000;
      endcase
   endfunction
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input [7:0] a, input w, input [31:0] d);
      integer n;
      @(posedge sys_clk);
      {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
      @(posedge sys_clk);
      penable <= 1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 20) begin
         bad_count++;
         wrap_up;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task pulse(input [2:0] k);
      @(posedge sys_clk);
      evtSel <= k;
      evtGo <= 1;
      @(posedge sys_clk);
      evtGo <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn, psel, penable, pwrite, evtGo, idle, paddr, pwdata, evtSel, endpointIrq} = 0;
      {bad_count, total_checks, seed, m} = {64'h0, 32'h0000_4965, 14'h1200};
      repeat (12) @(posedge sys_clk);
      rstn <= 1;
      apb(`OFS_DEVICE_ADDRESS_CTRL, 0, 0);
      chk(rd, 32'h0000_0100);
      apb(`OFS_IRQ_ENABLE_VIEW, 0, 0);
      chk(rd, 32'h0000_1200);
      apb(`OFS_PORT_CTRL, 0, 0);
      chk(rd & 32'h0000_0010, 0);
      pulse(4);
      for (i = 0; i < 6; i++) begin
         seed = nxt(seed);
         apb(`OFS_DEVICE_ADDRESS_CTRL, 1, seed);
         apb(`OFS_DEVICE_ADDRESS_CTRL, 0, 0);
         chk(rd, seed & 32'h0000_017F);
         apb(`OFS_PORT_CTRL, 1, seed);
         apb(`OFS_PORT_CTRL, 0, 0);
         chk(rd & 32'h0000_0010, seed & 32'h0000_0010);
         v = nxt(seed);
         seed = nxt(v);
         apb(`OFS_IRQ_ENABLE_SET, 1, v);
         apb(`OFS_IRQ_ENABLE_CLEAR, 1, seed);
         m = newMask(m, v, seed);
         apb(`OFS_IRQ_ENABLE_VIEW, 1, v);
         apb(`OFS_IRQ_ENABLE_VIEW, 0, 0);
         chk(rd, {18'h0, m});
      end
      apb(`OFS_IRQ_ENABLE_SET, 0, 0);
      chk(rd, 0);
      apb(8'h0C, 0, 0);
      chk({31'h0, err}, 1);
      apb(`OFS_IRQ_ENABLE_SET, 1, 32'h0000_2FFF);
      apb(`OFS_IRQ_PENDING_CLEAR, 1, 32'h0000_3F00);
      for (i = 1; i < 5; i++) begin
         pulse(i);
         apb(`OFS_IRQ_PENDING_VIEW, 0, 0);
         chk(rd, evtBits(i));
         chk({31'h0, irq}, 1);
         apb(`OFS_IRQ_PENDING_CLEAR, 1, 32'h0000_3F00);
      end
      apb(`OFS_DEVICE_ADDRESS_CTRL, 0, 0);
      chk(rd & 32'h0000_007F, 0);
      chk({31'h0, irq}, 0);
      endpointIrq <= seed[7:0] | 8'h81;
      apb(`OFS_IRQ_PENDING_VIEW, 0, 0);
      chk(rd, {24'h0, seed[7:0] | 8'h81});
      apb(`OFS_IRQ_ENABLE_CLEAR, 1, 32'h0000_2FFF);
      pulse(3);
      apb(`OFS_IRQ_PENDING_VIEW, 0, 0);
      chk({31'h0, irq}, 0);
      idle <= 1;
      i = 0;
      while (suspendMode !== 1'b1 && i < 40) begin
         @(posedge sys_clk);
         i++;
      end
      if (i >= 40) begin
         bad_count++;
         wrap_up;
      end
      chk({31'h0, i > 15}, 1);
      apb(`OFS_IRQ_PENDING_VIEW, 0, 0);
      chk(rd & 32'h0000_0100, 32'h0000_0100);
      idle <= 0;
      wrap_up;
   end
endmodule // usb_device_addr_and_irq_regs_bench

// [tb/usb_host_model.sv]
// Host side model that turns bench commands into bus event pulses.
`timescale 1ns/1ns
module usb_host_model (
   input wire sys_clk,
   input wire rstn,
   input wire [2:0] evtSel,
   input wire evtGo,
   input wire idle,
   output reg busActivity,
   output reg resumeDetected,
   output reg externalResumeDone,
   output reg frameStartSeen,
   output reg busResetDone
);
   // Registered so that every event is a clean one-cycle pulse.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         {busActivity, resumeDetected, externalResumeDone, frameStartSeen, busResetDone} <= 5'h0;
      end else begin
         busActivity <= !idle;
         resumeDetected <= evtGo && evtSel == 3'd1;
         externalResumeDone <= evtGo && evtSel == 3'd2;
         frameStartSeen <= evtGo && evtSel == 3'd3;
         busResetDone <= evtGo && evtSel == 3'd4;
      end
   end
endmodule // usb_host_model
